// *** verilog/dtc_pkg.sv ***
package dtc_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0L  = 8'h8A;
  localparam logic [7:0] ADDR_T1L  = 8'h8B;
  localparam logic [7:0] ADDR_T0H  = 8'h8C;
  localparam logic [7:0] ADDR_T1H  = 8'h8D;

  // ==========================================================
  // Control register fields
  localparam int CTRL_OVF1  = 7;
  localparam int CTRL_RUN1  = 6;
  localparam int CTRL_OVF0  = 5;
  localparam int CTRL_RUN0  = 4;
  localparam int CTRL_PEND1 = 3;
  localparam int CTRL_EDGE1 = 2;
  localparam int CTRL_PEND0 = 1;
  localparam int CTRL_EDGE0 = 0;

  // ==========================================================
  // Mode register fields
  localparam int MODE_CTR1_BASE = 4;
  localparam int MODE_CTR0_BASE = 0;
  localparam int MODE_GATE      = 3;
  localparam int MODE_CT        = 2;
  localparam int MODE_SEL_HIGH  = 1;
  localparam int MODE_SEL_LOW   = 0;

  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_AUTO  = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ==========================================================
  // Timing
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         MACHINE_CLKS  = 12;
  localparam logic [3:0] MCYC_MAX      = 4'(MACHINE_CLKS - 1);

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_req_type;

  typedef struct packed {
    logic ctr0_ovf;
    logic ext0;
    logic ctr1_ovf;
    logic ext1;
  } dtc_irq_type;

endpackage

// *** verilog/dtc_timer_counter.sv ***
`timescale 1ns/1ns
// Contract
// - Overflow flags set on overflow, cleared on vector
// - Run bits switch each counter on/off
// - External flags set by falling edge or low
// - Edge flags cleared on vector; level follows pin
// - Trigger bit one edge, zero level
// - Mode 0 is 13 bits, five-bit prescaler
// - Rollover to zero sets overflow flag
// - Setting run leaves counts untouched
// - Mode 1 full 16-bit cascade
// - Mode 2 low byte reloads from high
// - Counter 1 mode 3 holds count
// - Split low byte uses counter 0 controls
// - Split high byte times, uses counter 1 controls
// - Counter 1 still runs for baud source
// - Data bytes independent or combined per mode
// - Mode register layout gate, select, mode
// - Machine cycle is twelve clocks
// - Pin sampled per machine cycle, high-low counts
module dtc_timer_counter
(
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_b_i,
  // Special-function register access
  input  wire dtc_pkg::dtc_sfr_req_type sfr_req_i,
  output logic [7:0]                    sfr_rdata_o,
  // Interrupt vectoring
  input  wire dtc_pkg::dtc_irq_type     irq_ack_i,
  output dtc_pkg::dtc_irq_type          irq_req_o,
  output logic                          ctr1_ovf_pulse_o,
  // Pins
  input  wire logic                     ext_irq_pin_0_b_i,
  input  wire logic                     ext_irq_pin_1_b_i,
  input  wire logic                     count_input_pin_0_i,
  input  wire logic                     count_input_pin_1_i
);

  // ==========================================================
  // Pin synchronisers, order {cnt1, cnt0, ext_irq_pin_1, ext_irq_pin_0}
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [1:0] int_prev_ff;
  logic [3:0] nxt_sync1;
  logic [3:0] nxt_sync2;
  logic [1:0] nxt_int_prev;

  always_comb
  begin
    nxt_sync1    = {count_input_pin_1_i, count_input_pin_0_i,
                    ext_irq_pin_1_b_i, ext_irq_pin_0_b_i};
    nxt_sync2    = sync1_ff;
    nxt_int_prev = sync2_ff[1:0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_ff    <= 4'hF;
      sync2_ff    <= 4'hF;
      int_prev_ff <= 2'h3;
    end
    else
    begin
      sync1_ff    <= nxt_sync1;
      sync2_ff    <= nxt_sync2;
      int_prev_ff <= nxt_int_prev;
    end
  end

  // ==========================================================
  // Machine cycle divider and count pin sampling
  logic [3:0] mcyc_cnt_ff;
  logic [1:0] samp_ff;
  logic [3:0] nxt_mcyc_cnt;
  logic [1:0] nxt_samp;
  logic       mcyc_en;
  logic [1:0] pin_event;

  assign mcyc_en   = (mcyc_cnt_ff == dtc_pkg::MCYC_MAX);
  assign pin_event = {2{mcyc_en}} & samp_ff & ~sync2_ff[3:2];

  always_comb
  begin
    nxt_mcyc_cnt = mcyc_en ? 4'h0 : mcyc_cnt_ff + 4'h1;
    nxt_samp     = mcyc_en ? sync2_ff[3:2] : samp_ff;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mcyc_cnt_ff <= 4'h0;
      samp_ff     <= 2'h0;
    end
    else
    begin
      mcyc_cnt_ff <= nxt_mcyc_cnt;
      samp_ff     <= nxt_samp;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] ctrl_ff;
  logic [7:0] mode_ff;
  logic [7:0] t0l_ff;
  logic [7:0] t0h_ff;
  logic [7:0] t1l_ff;
  logic [7:0] t1h_ff;
  logic [7:0] rdata_ff;
  logic       baud_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] nxt_mode;
  logic [7:0] nxt_t0l;
  logic [7:0] nxt_t0h;
  logic [7:0] nxt_t1l;
  logic [7:0] nxt_t1h;
  logic [7:0] nxt_rdata;
  logic       nxt_baud;

  // Decoded controls
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic       run0;
  logic       run1;
  logic       tick0;
  logic       tick1;
  logic       tick0h;
  logic       wr_t0;
  logic       wr_t1;

  assign mode0 = mode_ff[dtc_pkg::MODE_CTR0_BASE +: 2];
  assign mode1 = mode_ff[dtc_pkg::MODE_CTR1_BASE +: 2];
  assign run0  = ctrl_ff[dtc_pkg::CTRL_RUN0];
  assign run1  = ctrl_ff[dtc_pkg::CTRL_RUN1];
  assign wr_t0 = sfr_req_i.wr && (sfr_req_i.addr == dtc_pkg::ADDR_T0L
                                  || sfr_req_i.addr == dtc_pkg::ADDR_T0H);
  assign wr_t1 = sfr_req_i.wr && (sfr_req_i.addr == dtc_pkg::ADDR_T1L
                                  || sfr_req_i.addr == dtc_pkg::ADDR_T1H);

  // Count enable: run and (no gate or pin high), tick1 off in mode 3; tick0h uses run1 only, no gate
  assign tick0  = run0
                  && (!mode_ff[dtc_pkg::MODE_CTR0_BASE + dtc_pkg::MODE_GATE] || sync2_ff[0])
                  && (mode_ff[dtc_pkg::MODE_CTR0_BASE + dtc_pkg::MODE_CT]
                      ? pin_event[0] : mcyc_en);
  assign tick1  = run1 && (mode1 != dtc_pkg::MODE_SPLIT)
                  && (!mode_ff[dtc_pkg::MODE_CTR1_BASE + dtc_pkg::MODE_GATE] || sync2_ff[1])
                  && (mode_ff[dtc_pkg::MODE_CTR1_BASE + dtc_pkg::MODE_CT]
                      ? pin_event[1] : mcyc_en);
  assign tick0h = run1 && mcyc_en;

  // One counting step; returns {overflow, high, low}
  function automatic logic [16:0] step
  (
    input logic [1:0] m,
    input logic       t,
    input logic [7:0] h,
    input logic [7:0] l
  );
    logic [16:0] r;
    logic [5:0]  p;
    r = {1'b0, h, l};
    p = 6'h00;
    if (t)
    begin
      case (m)
        dtc_pkg::MODE_13BIT:
        begin
          p       = {1'b0, l[4:0]} + 6'h01;
          r[7:0]  = {l[7:5], p[4:0]};
          if (p[5])
          begin
            r[16:8] = {1'b0, h} + 9'h001;
          end
        end
        dtc_pkg::MODE_16BIT: r = {1'b0, h, l} + 17'h00001;
        dtc_pkg::MODE_AUTO:  r = (l == 8'hFF) ? {1'b1, h, h} : {1'b0, h, l + 8'h01};
        default:             r = {l == 8'hFF, h, l + 8'h01};
      endcase
    end
    return r;
  endfunction

  logic [16:0] res0;
  logic [16:0] res1;
  logic [8:0]  res0h;
  logic        set_tf0;
  logic        set_tf1;
  logic        ovf1;

  always_comb
  begin
    res0  = step(mode0, tick0, t0h_ff, t0l_ff);
    res1  = step(mode1, tick1, t1h_ff, t1l_ff);
    res0h = {1'b0, t0h_ff} + {8'h00, tick0h};
    ovf1  = res1[16];
    if (mode0 == dtc_pkg::MODE_SPLIT)
    begin
      set_tf0 = res0[16];
      set_tf1 = res0h[8];
      nxt_t0h = res0h[7:0];
    end
    else
    begin
      set_tf0 = res0[16];
      set_tf1 = ovf1;
      nxt_t0h = res0[15:8];
    end
    nxt_t0l  = res0[7:0];
    nxt_t1l  = res1[7:0];
    nxt_t1h  = res1[15:8];
    nxt_baud = ovf1;
    nxt_mode = mode_ff;
    nxt_ctrl = ctrl_ff;
    // Software writes load at once
    if (sfr_req_i.wr)
    begin
      case (sfr_req_i.addr)
        dtc_pkg::ADDR_CTRL: nxt_ctrl = sfr_req_i.wdata;
        dtc_pkg::ADDR_MODE: nxt_mode = sfr_req_i.wdata;
        dtc_pkg::ADDR_T0L:  nxt_t0l  = sfr_req_i.wdata;
        dtc_pkg::ADDR_T0H:  nxt_t0h  = sfr_req_i.wdata;
        dtc_pkg::ADDR_T1L:  nxt_t1l  = sfr_req_i.wdata;
        dtc_pkg::ADDR_T1H:  nxt_t1h  = sfr_req_i.wdata;
        default:            nxt_ctrl = nxt_ctrl;
      endcase
    end
    // Vector clears, then hardware sets win
    nxt_ctrl[dtc_pkg::CTRL_OVF0] = (nxt_ctrl[dtc_pkg::CTRL_OVF0] && !irq_ack_i.ctr0_ovf)
                                   || set_tf0;
    nxt_ctrl[dtc_pkg::CTRL_OVF1] = (nxt_ctrl[dtc_pkg::CTRL_OVF1] && !irq_ack_i.ctr1_ovf)
                                   || set_tf1;
    if (ctrl_ff[dtc_pkg::CTRL_EDGE0])
    begin
      nxt_ctrl[dtc_pkg::CTRL_PEND0] = (nxt_ctrl[dtc_pkg::CTRL_PEND0] && !irq_ack_i.ext0)
                                      || (int_prev_ff[0] && !sync2_ff[0]);
    end
    else
    begin
      nxt_ctrl[dtc_pkg::CTRL_PEND0] = !sync2_ff[0];
    end
    if (ctrl_ff[dtc_pkg::CTRL_EDGE1])
    begin
      nxt_ctrl[dtc_pkg::CTRL_PEND1] = (nxt_ctrl[dtc_pkg::CTRL_PEND1] && !irq_ack_i.ext1)
                                      || (int_prev_ff[1] && !sync2_ff[1]);
    end
    else
    begin
      nxt_ctrl[dtc_pkg::CTRL_PEND1] = !sync2_ff[1];
    end
    // Registered read data
    nxt_rdata = rdata_ff;
    if (sfr_req_i.rd)
    begin
      case (sfr_req_i.addr)
        dtc_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
        dtc_pkg::ADDR_MODE: nxt_rdata = mode_ff;
        dtc_pkg::ADDR_T0L:  nxt_rdata = t0l_ff;
        dtc_pkg::ADDR_T0H:  nxt_rdata = t0h_ff;
        dtc_pkg::ADDR_T1L:  nxt_rdata = t1l_ff;
        dtc_pkg::ADDR_T1H:  nxt_rdata = t1h_ff;
        default:            nxt_rdata = dtc_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_ff  <= dtc_pkg::RST_CTRL;
      mode_ff  <= dtc_pkg::RST_MODE;
      t0l_ff   <= dtc_pkg::RST_COUNT;
      t0h_ff   <= dtc_pkg::RST_COUNT;
      t1l_ff   <= dtc_pkg::RST_COUNT;
      t1h_ff   <= dtc_pkg::RST_COUNT;
      rdata_ff <= dtc_pkg::RST_RDATA;
      baud_ff  <= 1'b0;
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl;
      mode_ff  <= nxt_mode;
      t0l_ff   <= nxt_t0l;
      t0h_ff   <= nxt_t0h;
      t1l_ff   <= nxt_t1l;
      t1h_ff   <= nxt_t1h;
      rdata_ff <= nxt_rdata;
      baud_ff  <= nxt_baud;
    end
  end

  // ==========================================================
  // Outputs
  assign sfr_rdata_o        = rdata_ff;
  assign ctr1_ovf_pulse_o   = baud_ff;
  assign irq_req_o          = {ctrl_ff[dtc_pkg::CTRL_OVF0], ctrl_ff[dtc_pkg::CTRL_PEND0],
                               ctrl_ff[dtc_pkg::CTRL_OVF1], ctrl_ff[dtc_pkg::CTRL_PEND1]};

  // ==========================================================
  // Assertions
  a_mcyc_period: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mcyc_en |-> ##12 mcyc_en) else $error("machine cycle not twelve clocks");
  a_mcyc_single: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mcyc_en |=> !mcyc_en [*8]) else $error("machine cycle enable too frequent");
  a_tf0_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    set_tf0 |=> irq_req_o.ctr0_ovf) else $error("overflow 0 flag not set");
  a_tf1_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    irq_ack_i.ctr1_ovf && !set_tf1 && !sfr_req_i.wr |=> !irq_req_o.ctr1_ovf)
    else $error("overflow 1 flag not cleared by vector");
  a_run_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !run0 && mode0 != dtc_pkg::MODE_SPLIT && !wr_t0 |=> $stable({t0h_ff, t0l_ff}))
    else $error("counter 0 moved while stopped");
  a_gate_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mode_ff[dtc_pkg::MODE_CTR0_BASE + dtc_pkg::MODE_GATE] && !sync2_ff[0] && !wr_t0
    |=> $stable(t0l_ff)) else $error("counter 0 moved while gated");
  a_level_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !ctrl_ff[dtc_pkg::CTRL_EDGE0] |=> irq_req_o.ext0 == !$past(sync2_ff[0]))
    else $error("level flag does not follow pin");
  a_edge_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ctrl_ff[dtc_pkg::CTRL_EDGE0] && int_prev_ff[0] && !sync2_ff[0] |=> irq_req_o.ext0)
    else $error("edge flag not set on falling edge");
  a_auto_reload: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mode1 == dtc_pkg::MODE_AUTO && mode0 != dtc_pkg::MODE_SPLIT && tick1 && t1l_ff == 8'hFF
    && !wr_t1 |=> t1l_ff == $past(t1h_ff) && $stable(t1h_ff) && irq_req_o.ctr1_ovf)
    else $error("auto reload wrong");
  a_mode3_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mode1 == dtc_pkg::MODE_SPLIT && !wr_t1 |=> $stable({t1h_ff, t1l_ff}))
    else $error("counter 1 moved in mode 3");

endmodule

// *** sim/dtc_far_end.sv ***
`timescale 1ns/1ns
module dtc_far_end
(
  // Clock
  input  wire logic ref_clk_i,
  // Pins toward the block
  output logic      ext_irq_pin_0_b_o,
  output logic      ext_irq_pin_1_b_o,
  output logic      count_input_pin_0_o,
  output logic      count_input_pin_1_o
);

  // ====================
  // Idle levels
  initial
  begin
    ext_irq_pin_0_b_o   = 1'b1;
    ext_irq_pin_1_b_o   = 1'b1;
    count_input_pin_0_o = 1'b1;
    count_input_pin_1_o = 1'b1;
  end

  // ====================
  // Count pin pulses, each level two machine cycles
  task automatic count_pulses(input int n);
    repeat (n)
    begin
      repeat (2 * dtc_pkg::MACHINE_CLKS) @(posedge ref_clk_i);
      #1 count_input_pin_0_o = 1'b0;
      repeat (2 * dtc_pkg::MACHINE_CLKS) @(posedge ref_clk_i);
      #1 count_input_pin_0_o = 1'b1;
    end
  endtask

  // ====================
  // Request level, held until the source drops it
  task automatic irq0_level(input logic lvl);
    @(posedge ref_clk_i);
    #1 ext_irq_pin_0_b_o = lvl;
  endtask

endmodule

// *** sim/dual_timer_counter_ext_irq_bench.sv ***
`timescale 1ns/1ns
module dual_timer_counter_ext_irq_bench;

  // ====================
  // Signals
  logic                     clk;
  logic                     rst_b;
  dtc_pkg::dtc_sfr_req_type req;
  logic [7:0]               rdata;
  dtc_pkg::dtc_irq_type     ack;
  dtc_pkg::dtc_irq_type     irq;
  logic                     pulse;
  logic                     i0_b;
  logic                     i1_b;
  logic                     c0;
  logic                     c1;
  logic [7:0]               v;
  int                       n_errors;
  int                       n_compared;

  // ====================
  // Instances
  dtc_far_end far
  (
    .ref_clk_i           (clk),
    .ext_irq_pin_0_b_o   (i0_b),
    .ext_irq_pin_1_b_o   (i1_b),
    .count_input_pin_0_o (c0),
    .count_input_pin_1_o (c1)
  );

  dtc_timer_counter DUT
  (
    .ref_clk_i           (clk),
    .rst_b_i             (rst_b),
    .sfr_req_i           (req),
    .sfr_rdata_o         (rdata),
    .irq_ack_i           (ack),
    .irq_req_o           (irq),
    .ctr1_ovf_pulse_o    (pulse),
    .ext_irq_pin_0_b_i   (i0_b),
    .ext_irq_pin_1_b_i   (i1_b),
    .count_input_pin_0_i (c0),
    .count_input_pin_1_i (c1)
  );

  // ====================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ====================
  // Tasks
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = {1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 req = '0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 req = '0;
    @(posedge clk);
    #1 d = rdata;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(nm, e, d);
  endtask

  task automatic pulse_ack(input dtc_pkg::dtc_irq_type a);
    ack = a;
    @(posedge clk);
    #1 ack = '0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_irq(input int b, input int lim);
    int k;
    k = 0;
    while (irq[b] !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      #1 k++;
    end
    if (k >= lim)
    begin
      $display("wrong value irq %0d expected 1 seen %b", b, irq[b]);
      n_errors++;
      print_verdict();
    end
  endtask

  // ====================
  // Sequence
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    req = '0;
    ack = '0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rdc("reset value", 8'h88 + 8'(i), 8'h00);
    end
    for (int i = 1; i < 6; i++)
    begin
      wr(8'h88 + 8'(i), 8'hA0 + 8'(i));
      rdc("readback", 8'h88 + 8'(i), 8'hA0 + 8'(i));
    end
    // Mode 1 rollover and vector clear
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    wait_irq(3, 14);
    rdc("t0 low", 8'h8A, 8'h00);
    rdc("t0 high", 8'h8C, 8'h00);
    pulse_ack(4'h8);
    rdc("control", 8'h88, 8'h10);
    wr(8'h88, 8'h00);
    // Mode 0 prescaler
    wr(8'h89, 8'h00);
    wr(8'h8A, 8'h1F);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    wait_irq(3, 14);
    rd(8'h8A, v);
    check("t0 prescaler", 8'h00, v & 8'h1F);
    rdc("t0 high", 8'h8C, 8'h00);
    wr(8'h88, 8'h00);
    // Mode 2 reload on counter 1
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hA5);
    wr(8'h8B, 8'hFF);
    wr(8'h88, 8'h40);
    wait_irq(1, 14);
    check("baud pulse", 8'h01, {7'h00, pulse});
    rdc("t1 reload", 8'h8B, 8'hA5);
    rdc("t1 high", 8'h8D, 8'hA5);
    check("baud pulse end", 8'h00, {7'h00, pulse});
    pulse_ack(4'h2);
    rdc("t1 flag cleared", 8'h88, 8'h40);
    wr(8'h88, 8'h00);
    // Gate low, level request
    wr(8'h89, 8'h09);
    wr(8'h8A, 8'h33);
    far.irq0_level(1'b0);
    wr(8'h88, 8'h10);
    idle(40);
    rdc("gated t0", 8'h8A, 8'h33);
    rdc("level set", 8'h88, 8'h12);
    pulse_ack(4'h4);
    rdc("level kept", 8'h88, 8'h12);
    far.irq0_level(1'b1);
    idle(4);
    rdc("level gone", 8'h88, 8'h10);
    wr(8'h88, 8'h00);
    // Edge request
    wr(8'h88, 8'h01);
    far.irq0_level(1'b0);
    wait_irq(2, 8);
    pulse_ack(4'h4);
    rdc("edge cleared", 8'h88, 8'h01);
    far.irq0_level(1'b1);
    // Counter function
    wr(8'h89, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    far.count_pulses(3);
    idle(30);
    rdc("pin count", 8'h8A, 8'h03);
    wr(8'h88, 8'h00);
    // Split mode
    wr(8'h89, 8'h33);
    wr(8'h8C, 8'hFF);
    wr(8'h8B, 8'h77);
    wr(8'h88, 8'h40);
    wait_irq(1, 14);
    rdc("split high", 8'h8C, 8'h00);
    rdc("t1 held", 8'h8B, 8'h77);
    rdc("split low", 8'h8A, 8'h03);
    print_verdict();
  end

endmodule
